/* core/lbpf_consts.svh */
// lbpf_consts.svh: offsets, bit positions and reset values of the pin
// function configuration slice.
// assumes: included by bare name from the design files.
`ifndef LBPF_CONSTS_SVH
`define LBPF_CONSTS_SVH
`define LBPF_OFF_CFG 12'h000
`define LBPF_OFF_STAT 12'h004
`define LBPF_BIT_REQ1_EN 2
`define LBPF_BIT_PAIR1_SEL 3
`define LBPF_BIT_REQ2_EN 4
`define LBPF_BIT_QUAL_EN 5
`define LBPF_BIT_TRIO_SEL 6
`define LBPF_BIT_STRAP_IND 7
`define LBPF_CFG_RST 8'h00
`define LBPF_WR_MASK 8'h7F
`endif

/* core/lbpf_pkg.sv */
// lbpf_pkg.sv: types of the pin function configuration slice.
// assumes: nothing beyond a SystemVerilog compiler.
package lbpf_pkg;
  typedef enum logic [1:0] {
    LBPF_ST_STRAP = 2'b01,
    LBPF_ST_RUN = 2'b10
  } lbpf_state_e;
endpackage

/* core/lbpf_mux_if.sv */
// lbpf_mux_if.sv: configuration bits passed from the register file to mux.
// assumes: one clock domain; driven by lbpf_top.
`timescale 1ns/100ps
`default_nettype none
interface lbpf_mux_if;
  logic req1_en;
  logic pair1_sel;
  logic req2_en;
  logic qual_en;
  logic trio_sel;
  modport regs (output req1_en, pair1_sel, req2_en, qual_en, trio_sel);
  modport mux (input req1_en, pair1_sel, req2_en, qual_en, trio_sel);
endinterface
`default_nettype wire

/* core/lbpf_mux.sv */
// lbpf_mux.sv: combinational routing of the shared pins.
// assumes: config bits from lbpf_top through lbpf_mux_if.
`timescale 1ns/100ps
`default_nettype none
module lbpf_mux (
  lbpf_mux_if.mux cfg,
  input wire logic slow_n,
  input wire logic flush_n,
  input wire logic [2:0] upper_addr,
  input wire logic grant1_n,
  input wire logic grant2_n,
  input wire logic io_addr_hit,
  input wire logic [2:0] trio_in,
  input wire logic [1:0] pair_in,
  output logic [1:0] pair_out,
  output logic [1:0] pair_oe_n,
  output logic [2:0] trio_out,
  output logic [2:0] trio_oe_n,
  output logic req1_n,
  output logic req2_n,
  output logic io_decode
);
  always_comb begin
    // pair0 carries slow-down or request 1 (input), pair1 flush or grant 1
    if (cfg.pair1_sel) begin
      pair_out = {grant1_n, 1'b1};
      pair_oe_n = 2'b01;
    end else begin
      pair_out = {flush_n, slow_n};
      pair_oe_n = 2'b00;
    end
    if (cfg.trio_sel) begin
      trio_out = {1'b1, grant2_n, 1'b1};
      trio_oe_n = 3'b101;
    end else begin
      trio_out = upper_addr;
      trio_oe_n = 3'b000;
    end
    req1_n = ~(cfg.req1_en & cfg.pair1_sel & ~pair_in[0]);
    req2_n = ~(cfg.req2_en & cfg.trio_sel & ~trio_in[0]);
    // qualifier only counts when routed onto its pin
    if (cfg.qual_en && cfg.trio_sel) begin
      io_decode = io_addr_hit & ~trio_in[2];
    end else begin
      io_decode = io_addr_hit;
    end
  end
endmodule
`default_nettype wire

/* core/lbpf_top.sv */
// lbpf_top.sv: APB register slice selecting shared pin functions.
// assumes: APB master on pclk; strap pin settled when presetn releases.
//
// Contract
// - bit 2 enables request 1 input, only while bit 3 is set
// - bit 3 picks slow-down/flush (0) or request/grant 1 (1)
// - bit 4 enables request 2 input, only while bit 6 is set
// - bit 5 set makes internal io decode also need qualifier low
// - qualifier enable only works while bit 6 is set
// - bit 6 picks upper address bits (0) or request/grant 2 + qualifier
// - bit 6 loads inverted grant strap at power-up, software may rewrite
// - bit 7 is read-only inverted strap latched at power-up
// - indicator 0 means strap high, 1 means strap low
`timescale 1ns/100ps
`default_nettype none
`include "lbpf_consts.svh"
module lbpf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic grant_strap_input,
  input wire logic slow_n,
  input wire logic flush_n,
  input wire logic [2:0] upper_system_address_bits,
  input wire logic grant1_n,
  input wire logic grant2_n,
  input wire logic io_addr_hit,
  input wire logic [2:0] trio_in,
  input wire logic [1:0] pair_in,
  output logic [1:0] pair_out,
  output logic [1:0] pair_oe_n,
  output logic [2:0] trio_out,
  output logic [2:0] trio_oe_n,
  output logic req1_n,
  output logic req2_n,
  output logic io_decode
);
  // ==========================================================
  // register state
  lbpf_pkg::lbpf_state_e state_r;
  logic [6:0] cfg_r;
  logic strap_ind_r;
  logic acc;
  logic hit_cfg;
  logic hit_stat;
  lbpf_mux_if mif ();

  assign acc = psel & penable;
  assign hit_cfg = (paddr == `LBPF_OFF_CFG);
  assign hit_stat = (paddr == `LBPF_OFF_STAT);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_cfg & ~hit_stat;

  // ==========================================================
  // strap capture: one clocked sample right after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= lbpf_pkg::LBPF_ST_STRAP;
    end else begin
      state_r <= lbpf_pkg::LBPF_ST_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_ind_r <= 1'b0;
    end else if (state_r == lbpf_pkg::LBPF_ST_STRAP) begin
      strap_ind_r <= ~grant_strap_input;
    end
  end

  // ==========================================================
  // config register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 7'(`LBPF_CFG_RST);
    end else if (state_r == lbpf_pkg::LBPF_ST_STRAP) begin
      cfg_r[`LBPF_BIT_TRIO_SEL] <= ~grant_strap_input;
    end else if (acc && pwrite && hit_cfg && pstrb[0]) begin
      // bit 7 is the indicator and has no storage here
      cfg_r <= 7'(pwdata[7:0] & `LBPF_WR_MASK);
    end
  end

  // ==========================================================
  // read data, registered on the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_cfg) begin
        prdata <= {24'h000000, strap_ind_r, cfg_r[6:0]};
      end else if (hit_stat) begin
        prdata <= {31'h00000000, strap_ind_r};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  assign mif.req1_en = cfg_r[`LBPF_BIT_REQ1_EN];
  assign mif.pair1_sel = cfg_r[`LBPF_BIT_PAIR1_SEL];
  assign mif.req2_en = cfg_r[`LBPF_BIT_REQ2_EN];
  assign mif.qual_en = cfg_r[`LBPF_BIT_QUAL_EN];
  assign mif.trio_sel = cfg_r[`LBPF_BIT_TRIO_SEL];

  lbpf_mux u_mux (
    .cfg(mif.mux),
    .slow_n(slow_n),
    .flush_n(flush_n),
    .upper_addr(upper_system_address_bits),
    .grant1_n(grant1_n),
    .grant2_n(grant2_n),
    .io_addr_hit(io_addr_hit),
    .trio_in(trio_in),
    .pair_in(pair_in),
    .pair_out(pair_out),
    .pair_oe_n(pair_oe_n),
    .trio_out(trio_out),
    .trio_oe_n(trio_oe_n),
    .req1_n(req1_n),
    .req2_n(req2_n),
    .io_decode(io_decode)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_write;
    acc && pwrite && hit_cfg && pstrb[0];
  endsequence

  // matches at the edge that follows the strap sample
  sequence s_strap_done;
    state_r == lbpf_pkg::LBPF_ST_STRAP ##1
      state_r == lbpf_pkg::LBPF_ST_RUN;
  endsequence

  sequence s_cfg_read;
    psel && !penable && !pwrite && hit_cfg;
  endsequence

  a_strap_preset: assert property (
    s_strap_done |-> cfg_r[6] == !$past(grant_strap_input))
    else $error("mux bit not preset from strap");
  a_ind_locked: assert property (
    state_r == lbpf_pkg::LBPF_ST_RUN |=> $stable(strap_ind_r))
    else $error("indicator changed after power-up");
  a_ind_match: assert property (
    s_strap_done |-> strap_ind_r == cfg_r[6])
    else $error("indicator and mux bit differ at power-up");
  a_sw_write: assert property (
    state_r == lbpf_pkg::LBPF_ST_RUN ##0 s_cfg_write |=>
      cfg_r[6:0] == $past(pwdata[6:0]))
    else $error("config write lost");
  a_req1_gate: assert property (
    !cfg_r[3] |-> req1_n)
    else $error("request 1 active without pair select");
  a_pair_route: assert property (
    !cfg_r[3] |-> pair_out == {flush_n, slow_n} && pair_oe_n == 2'b00)
    else $error("pair not driving slow-down and flush");
  a_req2_gate: assert property (
    !(cfg_r[4] && cfg_r[6]) |-> req2_n)
    else $error("request 2 active while gated");
  a_qual_dec: assert property (
    cfg_r[5] && cfg_r[6] && trio_in[2] |-> !io_decode)
    else $error("io decode ignored qualifier");
  a_trio_route: assert property (
    !cfg_r[6] |-> trio_out == upper_system_address_bits
      && trio_oe_n == 3'b000)
    else $error("upper address bits not driven");

  // ==========================================================
  // request modes, power-up mode and read path
  a_req1_pass: assert property (
    cfg_r[2] && cfg_r[3] && !pair_in[0] |-> !req1_n)
    else $error("request 1 not passed while enabled");
  a_req1_off: assert property (
    !cfg_r[2] |-> req1_n)
    else $error("request 1 active while disabled");
  a_pair_req: assert property (
    cfg_r[3] |-> pair_oe_n == 2'b01 && pair_out[1] == grant1_n)
    else $error("pair not in request and grant mode");
  a_req2_pass: assert property (
    cfg_r[4] && cfg_r[6] && !trio_in[0] |-> !req2_n)
    else $error("request 2 not passed while enabled");
  a_qual_off: assert property (
    !(cfg_r[5] && cfg_r[6]) |-> io_decode == io_addr_hit)
    else $error("io decode qualified while qualifier off");
  a_qual_pass: assert property (
    cfg_r[5] && cfg_r[6] && !trio_in[2] |-> io_decode == io_addr_hit)
    else $error("io decode blocked with qualifier low");
  a_trio_req: assert property (
    cfg_r[6] |-> trio_oe_n == 3'b101 && trio_out[1] == grant2_n)
    else $error("trio not in request and qualifier mode");
  a_boot_mode: assert property (
    s_strap_done |-> trio_oe_n[0] == !$past(grant_strap_input))
    else $error("pin mode after power-up does not follow strap");
  a_ind_strap: assert property (
    s_strap_done |-> strap_ind_r == !$past(grant_strap_input))
    else $error("indicator does not show inverted strap");
  a_ind_nowrite: assert property (
    state_r == lbpf_pkg::LBPF_ST_RUN ##0 s_cfg_write |=>
      strap_ind_r == $past(strap_ind_r))
    else $error("indicator changed by a write");
  a_ind_read: assert property (
    s_cfg_read |=> prdata[7] == $past(strap_ind_r))
    else $error("indicator not returned in read data");
  a_cfg_hold: assert property (
    state_r == lbpf_pkg::LBPF_ST_RUN
      && !(acc && pwrite && hit_cfg && pstrb[0]) |=> $stable(cfg_r))
    else $error("config changed without a write");
endmodule
`default_nettype wire

/* verification/lbpf_far.sv */
// lbpf_far.sv: local-bus masters and strap resistor beside the slice.
// assumes: released pins are pulled up on the board.
`timescale 1ns/100ps
`default_nettype none
module lbpf_far (
  input wire logic strap_up,
  input wire logic m1_req_n,
  input wire logic m2_req_n,
  input wire logic qual_n,
  input wire logic [1:0] pair_out,
  input wire logic [1:0] pair_oe_n,
  input wire logic [2:0] trio_out,
  input wire logic [2:0] trio_oe_n,
  output logic grant_strap_input,
  output logic [1:0] pair_in,
  output logic [2:0] trio_in
);
  // ==========
  // pin levels
  assign grant_strap_input = strap_up;
  assign pair_in[0] = pair_oe_n[0] ? m1_req_n : pair_out[0];
  assign pair_in[1] = pair_oe_n[1] ? 1'b1 : pair_out[1];
  assign trio_in[0] = trio_oe_n[0] ? m2_req_n : trio_out[0];
  assign trio_in[1] = trio_oe_n[1] ? 1'b1 : trio_out[1];
  assign trio_in[2] = trio_oe_n[2] ? qual_n : trio_out[2];
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// tb_top.sv: self-checking bench for the pin function slice.
// assumes: lbpf_top and lbpf_far compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, slow_n, flush_n, gs;
  logic grant1_n, grant2_n, io_addr_hit, m1, m2, qn, strap, ind, e;
  logic req1_n, req2_n, io_decode, pready, pslverr;
  logic [2:0] upper, trio_in, trio_out, trio_oe_n;
  logic [1:0] pair_in, pair_out, pair_oe_n;
  logic [3:0] pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] c;
  int mismatches, num_checks;
  lbpf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .grant_strap_input(gs),
    .slow_n, .flush_n, .upper_system_address_bits(upper), .grant1_n,
    .grant2_n, .io_addr_hit, .trio_in, .pair_in, .pair_out, .pair_oe_n,
    .trio_out, .trio_oe_n, .req1_n, .req2_n, .io_decode);
  lbpf_far far_u (.strap_up(strap), .m1_req_n(m1), .m2_req_n(m2),
    .qual_n(qn), .pair_out, .pair_oe_n, .trio_out, .trio_oe_n,
    .grant_strap_input(gs), .pair_in, .trio_in);
  // ==========
  // tasks
  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // config word as read back: indicator on top of the stored bits
  function automatic logic [31:0] exp_cfg(input logic i,
    input logic [6:0] v);
    return {24'h0, i, v};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========
  // main sequence
  initial begin
    psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
    paddr <= 12'h000; pwdata <= 32'h0; pstrb <= 4'hF;
    {slow_n, flush_n, upper, grant1_n, grant2_n, io_addr_hit} <= 8'hFF;
    {m1, m2, qn} <= 3'h7;
    void'($urandom(32'h6E10));
    for (int k = 0; k < 2; k++) begin
      presetn <= 1'b0; strap <= k[0] ? 1'b0 : 1'b1;
      ind = k[0];
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk("cfg_reset", r, exp_cfg(ind, {ind, 6'h00}));
      apb(1'b0, 12'h004, 32'h0);
      chk("indicator", r[0], ind);
      for (int i = 0; i < 30; i++) begin
        c = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
        apb(1'b1, 12'h000, {24'h0, c});
        r = $urandom;
        {slow_n, flush_n, upper, grant1_n, grant2_n, io_addr_hit} <= r[7:0];
        {m1, m2, qn} <= r[10:8];
        @(posedge pclk);
        #1;
        chk("req1_n", req1_n, !(c[2] && c[3] && !m1));
        chk("req2_n", req2_n, !(c[4] && c[6] && !m2));
        chk("io_decode", io_decode,
          io_addr_hit && !(c[5] && c[6] && qn));
        chk("pair", {pair_oe_n, c[3] ? {pair_out[1], 1'b0} : pair_out},
          c[3] ? {2'b01, grant1_n, 1'b0}
          : {2'b00, flush_n, slow_n});
        chk("trio", {trio_oe_n, c[6] ? {1'b0, trio_out[1], 1'b0} : trio_out},
          c[6] ? {4'b1010, grant2_n, 1'b0} : {3'b000, upper});
        apb(1'b0, 12'h000, 32'h0);
        chk("cfg_read", r, exp_cfg(ind, c[6:0]));
      end
    end
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", e, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
